// file: pkg/pwmc_map.svh
// Register offsets, field positions and reset values of the pulse unit
`ifndef PWMC_MAP_SVH
`define PWMC_MAP_SVH
`define PWMC_CTRL       8'h00
`define PWMC_PRESC      8'h04
`define PWMC_PERIOD     8'h08
`define PWMC_CMP        8'h14
`define PWMC_DTIME      8'h2c
`define PWMC_OUTCFG     8'h30
`define PWMC_CAPCFG     8'h34
`define PWMC_INTEN      8'h38
`define PWMC_INTSTS     8'h3c
`define PWMC_TRGEN      8'h40
`define PWMC_CNT        8'h44
`define PWMC_CAPDAT     8'h80
`define PWMC_PERIOD_RST 16'hffff
`define PWMC_CTRL_RUN   0
`define PWMC_CTRL_COMP  1
`define PWMC_CTRL_MODE  2
`define PWMC_CTRL_BLVL  8
`define PWMC_CTRL_BPIN  9
`define PWMC_CTRL_BSYS  10
`define PWMC_CTRL_BOUT  11
`define PWMC_OC_POL     0
`define PWMC_OC_MEN     8
`define PWMC_OC_MLVL    16
`define PWMC_OC_OE      24
`define PWMC_CC_EN      0
`define PWMC_CC_RISE    8
`define PWMC_CC_FALL    16
`define PWMC_CC_RLD     24
`define PWMC_INT_ZERO   0
`define PWMC_INT_PER    3
`define PWMC_INT_CMP    6
`define PWMC_INT_BRK    12
`define PWMC_INT_RISE   13
`define PWMC_INT_FALL   19
`define PWMC_FILT_LEN   3
`endif

// file: pkg/pwmc_pkg.sv
// Types shared by the pulse unit modules
package pwmc_pkg;
   typedef enum logic [1:0] {
      PWMC_UP   = 2'b00,
      PWMC_DOWN = 2'b01,
      PWMC_UPDN = 2'b10
   } pwmc_mode_t;
   typedef struct packed {
      logic zero;
      logic period;
   } pwmc_evt_t;
endpackage

// file: hdl/pwmc_counter.sv
// One 16-bit pulse unit counter: up, down or up-down
`timescale 1ns/1ps
module pwmc_counter #(
   parameter int W = 16
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                tick,
   input  wire logic                run,
   input  wire logic                reload,
   input  wire pwmc_pkg::pwmc_mode_t mode,
   input  wire logic [W-1:0]        period,
   output logic [W-1:0]             cnt,
   output pwmc_pkg::pwmc_evt_t      evt
);
   logic down;

   // Events only on a prescaler tick, so each fires once per step
   always_comb begin
      evt.zero   = tick & (cnt == '0);
      evt.period = tick & (cnt == period);
   end

   // Counting; a code of 2'b11 falls back to up counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt  <= '0;
         down <= 1'b0;
      end else if (!run) begin
         cnt  <= '0;
         down <= 1'b0;
      end else if (reload) begin
         cnt  <= (mode == pwmc_pkg::PWMC_DOWN) ? period : '0;
         down <= 1'b0;
      end else if (tick) begin
         unique case (mode)
            pwmc_pkg::PWMC_UP:
               cnt <= (cnt >= period) ? '0 : cnt + 1'b1;
            pwmc_pkg::PWMC_DOWN:
               cnt <= (cnt == '0) ? period : cnt - 1'b1;
            pwmc_pkg::PWMC_UPDN: begin
               // Turn at both ends for one symmetric period
               if (!down) begin
                  if (cnt >= period) begin
                     down <= 1'b1;
                     cnt  <= (cnt == '0) ? cnt : cnt - 1'b1;
                  end else begin
                     cnt <= cnt + 1'b1;
                  end
               end else if (cnt == '0) begin
                  down <= 1'b0;
                  cnt  <= (period == '0) ? cnt : cnt + 1'b1;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            default: cnt <= (cnt >= period) ? '0 : cnt + 1'b1;
         endcase
      end
   end

   // Up-down turns at the period value
   property p_updn_turn;
      @(posedge pclk) disable iff (!presetn)
      run && !reload && tick && mode == pwmc_pkg::PWMC_UPDN && !down
         && cnt == period && period != '0 |=> down;
   endproperty
   a_updn_turn: assert property (p_updn_turn)
      else $error("up-down counter did not turn at period");

   // Up counting wraps to zero after the period value
   property p_up_wrap;
      @(posedge pclk) disable iff (!presetn)
      run && !reload && tick && mode == pwmc_pkg::PWMC_UP
         && cnt == period |=> cnt == '0;
   endproperty
   a_up_wrap: assert property (p_up_wrap)
      else $error("up counter did not wrap to zero");
endmodule

// file: hdl/pwmc_capmem.sv
// Capture result store: one word per entry, registered read port
`timescale 1ns/1ps
module pwmc_capmem #(
   parameter int W = 16,
   parameter int N = 12
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic [N-1:0]         we,
   input  wire logic [N-1:0][W-1:0]  wdata,
   input  wire logic [3:0]           raddr,
   output logic [W-1:0]              rdata
);
   logic [N-1:0][W-1:0] mem;

   // Each entry has its own write strobe so captures never collide
   for (genvar e = 0; e < N; e++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mem[e] <= '0;
         end else if (we[e]) begin
            mem[e] <= wdata[e];
         end
      end
   end

   // Registered read; out of range reads give zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= '0;
      end else begin
         rdata <= (int'(raddr) < N) ? mem[raddr] : '0;
      end
   end
endmodule

// file: hdl/pwmc_top.sv
// Six-channel pulse unit with dead time, brake and capture
//
// Contract
// - Six channels, each output or capture
// - 12-bit prescaler divides by 1 to 4096
// - Three independent 16-bit counters
// - Counters count up, down or up-down
// - Compare against counter raises events
// - Independent mode or three complementary pairs
// - Complementary pulse uses two compare values
// - 12-bit dead time between paired edges
// - Per-pin polarity, mask level, output enable
// - Brake from pin, brown-out or lockup
// - Brake pin passes a noise filter
// - Edge brake holds until flag cleared
// - Level brake releases when condition ends
// - Interrupts on zero, period, compare, brake
// - Converter trigger on zero, period, compare
// - Capture counter on rising, falling or both
// - Twelve 16-bit results, rise and fall
// - Interrupts on rising and falling capture
// - Capture may reload the counter
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwmc_top #(
   parameter int CH = 6,
   parameter int CW = 16,
   parameter int PW = 12,
   parameter int DW = 12
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [CH-1:0] cap_in,
   input  wire logic          brake_pin,
   input  wire logic          bod_evt,
   input  wire logic          lockup,
   output logic [CH-1:0]      pwm_out,
   output logic [CH-1:0]      pwm_oe_n,
   output logic               adc_trig,
   output logic               irq
);
   localparam int NC = CH / 2;
   localparam int IW = 25;

   logic [16:0]            ctrl;
   logic [PW-1:0]          presc;
   logic [NC-1:0][CW-1:0]  period;
   logic [CH-1:0][CW-1:0]  cmp;
   logic [DW-1:0]          dtime;
   logic [31:0]            outcfg;
   logic [31:0]            capcfg;
   logic [IW-1:0]          inten;
   logic [IW-1:0]          intsts;
   logic [11:0]            trgen;
   logic                   acc;
   logic                   wr;
   logic [31:0]            rd_val;
   logic                   rd_hit;
   logic                   cap_hit;
   logic [CW-1:0]          cap_rdata;
   logic [PW-1:0]          psc_cnt;
   logic                   tick;
   logic                   run;
   logic [NC-1:0][CW-1:0]  cnt;
   pwmc_pkg::pwmc_evt_t [NC-1:0] evt;
   logic [NC-1:0]          ev_zero;
   logic [NC-1:0]          ev_per;
   logic [CH-1:0]          ev_cmp;
   logic [NC-1:0]          reload;
   logic [CH-1:0]          cap_prev;
   logic [CH-1:0]          cap_rise;
   logic [CH-1:0]          cap_fall;
   logic [2*CH-1:0]        cap_we;
   logic [2*CH-1:0][CW-1:0] cap_wd;
   logic [`PWMC_FILT_LEN-1:0] filt_sh;
   logic                   brk_filt;
   logic                   brk_src;
   logic                   brk_prev;
   logic                   brk_act;
   logic [IW-1:0]          set_vec;
   logic [NC-1:0]          raw_cp;
   logic [NC-1:0]          raw_q;
   logic [NC-1:0][DW-1:0]  dt_cnt;
   logic [NC-1:0]          pa;
   logic [NC-1:0]          pb;
   logic [CH-1:0]          pre;
   logic [CH-1:0]          next_out;
   logic [CH-1:0]          cap_en;

   assign run    = ctrl[`PWMC_CTRL_RUN];
   assign cap_en = capcfg[`PWMC_CC_EN +: CH];

   // One wait state on every access keeps reads from the store aligned
   assign acc = psel & penable & ~pready;
   assign wr  = psel & penable & pready & pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= acc;
         pslverr <= acc & ~rd_hit;
         if (acc && !pwrite) begin
            prdata <= cap_hit ? {16'h0000, cap_rdata} : rd_val;
         end
      end
   end

   // Read decode; unmapped addresses answer with an error
   always_comb begin
      rd_val  = '0;
      cap_hit = (paddr >= `PWMC_CAPDAT) && (paddr < 8'hb0);
      rd_hit  = cap_hit;
      unique case (paddr)
         `PWMC_CTRL:   rd_val = 32'(ctrl);
         `PWMC_PRESC:  rd_val = 32'(presc);
         `PWMC_DTIME:  rd_val = 32'(dtime);
         `PWMC_OUTCFG: rd_val = outcfg;
         `PWMC_CAPCFG: rd_val = capcfg;
         `PWMC_INTEN:  rd_val = 32'(inten);
         `PWMC_INTSTS: rd_val = 32'(intsts);
         `PWMC_TRGEN:  rd_val = 32'(trgen);
         default:      rd_val = '0;
      endcase
      if (paddr == `PWMC_CTRL || paddr == `PWMC_PRESC
          || (paddr >= `PWMC_DTIME && paddr <= `PWMC_TRGEN)) begin
         rd_hit = 1'b1;
      end
      for (int i = 0; i < NC; i++) begin
         if (paddr == `PWMC_PERIOD + 8'(4 * i)) begin
            rd_val = 32'(period[i]);
            rd_hit = 1'b1;
         end
         if (paddr == `PWMC_CNT + 8'(4 * i)) begin
            rd_val = 32'(cnt[i]);
            rd_hit = 1'b1;
         end
      end
      for (int i = 0; i < CH; i++) begin
         if (paddr == `PWMC_CMP + 8'(4 * i)) begin
            rd_val = 32'(cmp[i]);
            rd_hit = 1'b1;
         end
      end
   end

   // Configuration writes at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl   <= '0;
         presc  <= '0;
         period <= {NC{`PWMC_PERIOD_RST}};
         cmp    <= '0;
         dtime  <= '0;
         outcfg <= '0;
         capcfg <= '0;
         inten  <= '0;
         trgen  <= '0;
      end else if (wr) begin
         if (paddr == `PWMC_CTRL)   ctrl   <= pwdata[16:0];
         if (paddr == `PWMC_PRESC)  presc  <= pwdata[PW-1:0];
         if (paddr == `PWMC_DTIME)  dtime  <= pwdata[DW-1:0];
         if (paddr == `PWMC_OUTCFG) outcfg <= pwdata;
         if (paddr == `PWMC_CAPCFG) capcfg <= pwdata;
         if (paddr == `PWMC_INTEN)  inten  <= pwdata[IW-1:0];
         if (paddr == `PWMC_TRGEN)  trgen  <= pwdata[11:0];
         for (int i = 0; i < NC; i++) begin
            if (paddr == `PWMC_PERIOD + 8'(4 * i))
               period[i] <= pwdata[CW-1:0];
         end
         for (int i = 0; i < CH; i++) begin
            if (paddr == `PWMC_CMP + 8'(4 * i)) cmp[i] <= pwdata[CW-1:0];
         end
      end
   end

   // Shared prescaler: value N-1 gives a tick every N clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psc_cnt <= '0;
      end else if (!run || tick) begin
         psc_cnt <= '0;
      end else begin
         psc_cnt <= psc_cnt + 1'b1;
      end
   end
   assign tick = run & (psc_cnt >= presc); // no wrap when lowered

   // Three counters, channels 2g and 2g+1 share counter g
   for (genvar g = 0; g < NC; g++) begin : g_cnt
      pwmc_counter #(.W(CW)) u_cnt (
         .pclk    (pclk),
         .presetn (presetn),
         .tick    (tick),
         .run     (run),
         .reload  (reload[g]),
         .mode    (pwmc_pkg::pwmc_mode_t'(ctrl[`PWMC_CTRL_MODE+2*g +: 2])),
         .period  (period[g]),
         .cnt     (cnt[g]),
         .evt     (evt[g])
      );
      assign ev_zero[g] = evt[g].zero;
      assign ev_per[g]  = evt[g].period;
      assign reload[g]  = |((cap_rise[2*g +: 2] | cap_fall[2*g +: 2])
                            & capcfg[`PWMC_CC_RLD+2*g +: 2]);
      // Pair pulse high between the two compare values
      assign raw_cp[g] = (cnt[g] >= cmp[2*g]) && (cnt[g] < cmp[2*g+1]);
      assign pa[g] = raw_q[g] & (dt_cnt[g] == '0);
      assign pb[g] = ~raw_q[g] & (dt_cnt[g] == '0);
      // Any edge of the pair pulse restarts the dead time
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            raw_q[g]  <= 1'b0;
            dt_cnt[g] <= '0;
         end else if (raw_cp[g] != raw_q[g]) begin
            raw_q[g]  <= raw_cp[g];
            dt_cnt[g] <= dtime;
         end else if (dt_cnt[g] != '0) begin
            dt_cnt[g] <= dt_cnt[g] - 1'b1;
         end
      end
   end

   // Per-channel compare, output shaping and capture strobes
   for (genvar c = 0; c < CH; c++) begin : g_ch
      assign ev_cmp[c] = tick & (cnt[c/2] == cmp[c]);
      assign pre[c] = ctrl[`PWMC_CTRL_COMP]
                    ? ((c % 2 == 0) ? pa[c/2] : pb[c/2])
                    : (cnt[c/2] < cmp[c]);
      always_comb begin
         next_out[c] = pre[c] ^ outcfg[`PWMC_OC_POL+c];
         if (outcfg[`PWMC_OC_MEN+c])
            next_out[c] = outcfg[`PWMC_OC_MLVL+c];
         if (brk_act)
            next_out[c] = ctrl[`PWMC_CTRL_BOUT+c];
      end
      assign cap_rise[c] = cap_en[c] & capcfg[`PWMC_CC_RISE+c]
                         & cap_in[c] & ~cap_prev[c];
      assign cap_fall[c] = cap_en[c] & capcfg[`PWMC_CC_FALL+c]
                         & ~cap_in[c] & cap_prev[c];
      assign cap_we[2*c]   = cap_rise[c];
      assign cap_we[2*c+1] = cap_fall[c];
      assign cap_wd[2*c]   = cnt[c/2];
      assign cap_wd[2*c+1] = cnt[c/2];
   end

   // Pins: a capture channel never drives its pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out  <= '0;
         pwm_oe_n <= '1;
         cap_prev <= '0;
      end else begin
         pwm_out  <= next_out;
         pwm_oe_n <= ~(outcfg[`PWMC_OC_OE +: CH] & ~cap_en);
         cap_prev <= cap_in;
      end
   end

   // Rise results at even entries, fall results at odd entries
   pwmc_capmem #(.W(CW), .N(2*CH)) u_capmem (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (cap_we),
      .wdata   (cap_wd),
      .raddr   (paddr[5:2]),
      .rdata   (cap_rdata)
   );

   // Pin brake filter: level changes only after agreeing samples
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_sh  <= '0;
         brk_filt <= 1'b0;
         brk_prev <= 1'b0;
      end else begin
         filt_sh  <= {filt_sh[`PWMC_FILT_LEN-2:0], brake_pin};
         if (&filt_sh) brk_filt <= 1'b1;
         else if (~|filt_sh) brk_filt <= 1'b0;
         brk_prev <= brk_src;
      end
   end
   assign brk_src = (ctrl[`PWMC_CTRL_BPIN] & brk_filt)
                  | (ctrl[`PWMC_CTRL_BSYS] & (bod_evt | lockup));
   // Edge brake lasts as long as its flag, level brake as its source
   assign brk_act = ctrl[`PWMC_CTRL_BLVL] ? brk_src
                  : intsts[`PWMC_INT_BRK];

   assign set_vec = {cap_fall, cap_rise, brk_src & ~brk_prev,
                     ev_cmp, ev_per, ev_zero};

   // Sticky flags, write one to clear; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         intsts <= '0;
      end else if (wr && paddr == `PWMC_INTSTS) begin
         intsts <= (intsts & ~pwdata[IW-1:0]) | set_vec;
      end else begin
         intsts <= intsts | set_vec;
      end
   end

   // Request line and converter trigger pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq      <= 1'b0;
         adc_trig <= 1'b0;
      end else begin
         irq      <= |(intsts & inten);
         adc_trig <= |(set_vec[11:0] & trgen);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_cmp_flag;
      ev_cmp[0] |=> intsts[`PWMC_INT_CMP];
   endproperty
   a_cmp_flag: assert property (p_cmp_flag)
      else $error("compare event did not set its flag");

   property p_set_wins;
      wr && paddr == `PWMC_INTSTS && pwdata[0] && ev_zero[0]
         |=> intsts[`PWMC_INT_ZERO];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost during flag clear");

   property p_trig;
      ev_zero[0] && trgen[`PWMC_INT_ZERO] |=> adc_trig;
   endproperty
   a_trig: assert property (p_trig)
      else $error("zero event gave no converter trigger");

   property p_mask;
      !brk_act && outcfg[`PWMC_OC_MEN] |=> pwm_out[0] == $past(outcfg[16]);
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked output not at mask level");

   property p_brk_edge;
      !ctrl[`PWMC_CTRL_BLVL] && intsts[`PWMC_INT_BRK]
         |=> pwm_out == $past(ctrl[16:11]);
   endproperty
   a_brk_edge: assert property (p_brk_edge)
      else $error("edge brake not holding brake level");

   property p_brk_lvl;
      ctrl[`PWMC_CTRL_BLVL] && !brk_src && outcfg[`PWMC_OC_MEN]
         |=> pwm_out[0] == $past(outcfg[`PWMC_OC_MLVL]);
   endproperty
   a_brk_lvl: assert property (p_brk_lvl)
      else $error("level brake did not release");

   property p_dead;
      ctrl[`PWMC_CTRL_COMP] && dtime != '0 && raw_cp[0] != raw_q[0]
         |=> !pa[0] && !pb[0];
   endproperty
   a_dead: assert property (p_dead)
      else $error("dead time shorter than programmed");

   property p_cap_oe;
      cap_en[0] |=> pwm_oe_n[0];
   endproperty
   a_cap_oe: assert property (p_cap_oe)
      else $error("capture channel drives its pin");

   property p_presc;
      tick && presc == 12'h003 && $stable(presc)
         |=> (!tick || presc != 12'h003) [*3];
   endproperty
   a_presc: assert property (p_presc)
      else $error("prescaler tick spacing wrong");
endmodule

// file: tb/pwmc_stage_model.sv
// Far-side model: power stage pins, capture and brake sources
`timescale 1ns/1ps
module pwmc_stage_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [5:0] pwm_out,
   input  wire logic [5:0] pwm_oe_n,
   input  wire logic [5:0] cap_req,
   input  wire logic       brk_req,
   output logic [5:0]      cap_in,
   output logic            brake_pin,
   output logic [5:0]      pin
);
   // Sources change just after an edge, like a synchronous driver
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_in    <= 6'h00;
         brake_pin <= 1'b0;
      end else begin
         cap_in    <= cap_req;
         brake_pin <= brk_req;
      end
   end
   // Released pins fall to the gate pull-down level
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pin[i] = pwm_oe_n[i] ? 1'b0 : pwm_out[i];
      end
   end
endmodule

// file: tb/pwmc_top_tb_top.sv
// Self-checking bench for the pulse unit
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwmc_top_tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, adc_trig, irq, brake_pin;
   logic [5:0]  cap_in, pwm_out, pwm_oe_n, pin;
   logic [5:0]  cap_req = 6'h00;
   logic        brk_req = 1'b0;
   logic        bod_evt = 1'b0;
   logic        lockup = 1'b0;
   logic [31:0] q;
   logic        err;
   int          n_errors = 0;
   int          checks = 0;
   int          g, c;

   always #4 pclk = ~pclk;

   pwmc_top u_pwmc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
      .brake_pin(brake_pin), .bod_evt(bod_evt), .lockup(lockup),
      .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .adc_trig(adc_trig),
      .irq(irq));
   pwmc_stage_model u_pwmc_stage_model (.pclk(pclk), .presetn(presetn),
      .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .cap_req(cap_req),
      .brk_req(brk_req), .cap_in(cap_in), .brake_pin(brake_pin), .pin(pin));

   task automatic summarize;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; pready sampled at rising edges, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         summarize();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Cycles between two converter triggers, bounded
   task automatic gap;
      int n;
      n = 0;
      g = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (adc_trig !== 1'b1 && n < 400);
      do begin
         @(negedge pclk);
         g++;
      end while (adc_trig !== 1'b1 && g < 400);
      if (n == 400 || g == 400) begin
         n_errors++;
         summarize();
      end
      @(posedge pclk);
   endtask

   // High cycles of one pin over ten cycles, one counter period
   task automatic hi(input int ch);
      c = 0;
      repeat (10) begin
         @(negedge pclk);
         c += pin[ch];
      end
      @(posedge pclk);
   endtask

   task automatic t_reset;
      check({26'h0, pwm_oe_n}, 32'h3f);
      apb(1'b0, `PWMC_PERIOD + 8'h08, 32'h0);
      check(q, 32'hffff);
      apb(1'b0, 8'hb0, 32'h0);
      check({31'h0, err}, 32'h1);
      check(q, 32'h0);
      $display("reset test done");
   endtask

   // Every mode code with two dividers; trigger on counter zero
   task automatic t_count;
      apb(1'b1, `PWMC_PERIOD, 32'h9);
      apb(1'b1, `PWMC_TRGEN, 32'h1);
      for (int p = 0; p < 4; p += 3) begin
         for (int m = 0; m < 4; m++) begin
            apb(1'b1, `PWMC_PRESC, p);
            apb(1'b1, `PWMC_CTRL, 32'h1 | (m << 2));
            gap();
            gap();
            check(g, (m == 2 ? 18 : 10) * (p + 1));
         end
      end
      apb(1'b1, `PWMC_PRESC, 32'h0);
      apb(1'b1, `PWMC_CMP, 32'h4);
      apb(1'b1, `PWMC_TRGEN, 32'h40);
      apb(1'b1, `PWMC_CTRL, 32'h1);
      gap();
      gap();
      check(g, 10);
      apb(1'b1, `PWMC_TRGEN, 32'h0);
      $display("counter test done");
   endtask

   task automatic t_out;
      apb(1'b1, `PWMC_CMP, 32'h3);
      apb(1'b1, `PWMC_OUTCFG, 32'h0100_0000);
      hi(0);
      check(c, 3);
      check({31'h0, pwm_oe_n[0]}, 32'h0);
      apb(1'b1, `PWMC_OUTCFG, 32'h0100_0001);
      hi(0);
      check(c, 7);
      apb(1'b1, `PWMC_OUTCFG, 32'h0101_0100);
      hi(0);
      check(c, 10);
      $display("output test done");
   endtask

   // Pair 0 with one cycle of dead time on each rising edge
   task automatic t_comp;
      apb(1'b1, `PWMC_CMP + 8'h04, 32'h6);
      apb(1'b1, `PWMC_CMP, 32'h2);
      apb(1'b1, `PWMC_DTIME, 32'h1);
      apb(1'b1, `PWMC_OUTCFG, 32'h0300_0000);
      apb(1'b1, `PWMC_CTRL, 32'h3);
      hi(0);
      check(c, 3);
      hi(1);
      check(c, 5);
      $display("pair test done");
   endtask

   task automatic brk(input logic [31:0] ctrl, input int src, input int len);
      apb(1'b1, `PWMC_CTRL, ctrl);
      repeat (6) @(posedge pclk);
      brk_req <= (src == 0);
      bod_evt <= (src == 1);
      lockup <= (src == 2);
      repeat (len) @(posedge pclk);
      brk_req <= 1'b0;
      bod_evt <= 1'b0;
      lockup <= 1'b0;
   endtask

   task automatic t_brake;
      apb(1'b1, `PWMC_OUTCFG, 32'h0101_0100);
      apb(1'b1, `PWMC_INTEN, 32'h0);
      brk(32'h301, 0, 1);
      repeat (6) @(posedge pclk);
      check(pwm_out[0], 1'b1);
      for (int s = 0; s < 3; s++) begin
         brk(s == 0 ? 32'h301 : 32'h501, s, 8);
         check(pwm_out[0], 1'b0);
         repeat (8) @(posedge pclk);
         check(pwm_out[0], 1'b1);
      end
      apb(1'b1, `PWMC_INTSTS, 32'h1000);
      brk(32'h201, 0, 8);
      repeat (10) @(posedge pclk);
      check(pwm_out[0], 1'b0);
      apb(1'b0, `PWMC_INTSTS, 32'h0);
      check(q[12], 1'b1);
      apb(1'b1, `PWMC_INTSTS, 32'h1000);
      repeat (4) @(posedge pclk);
      check(pwm_out[0], 1'b1);
      $display("brake test done");
   endtask

   // Rise reloads the counter, so the fall capture holds the pulse width
   task automatic t_cap;
      apb(1'b1, `PWMC_CTRL, 32'h1);
      apb(1'b1, `PWMC_PERIOD, 32'hffff);
      apb(1'b1, `PWMC_CAPCFG, 32'h0101_0101);
      apb(1'b1, `PWMC_INTEN, 32'h0008_2000);
      apb(1'b1, `PWMC_INTSTS, 32'hffff_ffff);
      cap_req <= 6'h01;
      repeat (20) @(posedge pclk);
      cap_req <= 6'h00;
      repeat (4) @(posedge pclk);
      check(irq, 1'b1);
      apb(1'b0, `PWMC_INTSTS, 32'h0);
      check(q & 32'h0008_2000, 32'h0008_2000);
      apb(1'b0, `PWMC_CAPDAT + 8'h04, 32'h0);
      check(q >= 32'd18 && q <= 32'd22, 1'b1);
      apb(1'b1, `PWMC_INTSTS, 32'h0008_2000);
      repeat (2) @(posedge pclk);
      check(irq, 1'b0);
      $display("capture test done");
   endtask

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_count();
      t_out();
      t_comp();
      t_brake();
      t_cap();
      summarize();
   end
endmodule
